// *** design/thc_class_if.sv ***
`timescale 1ns/10ps
// Carries a header doubleword into the classifier and its verdict back.
interface thc_class_if;
   logic [31:0] dw;
   logic [3:0]  cls;
   logic        ok;
   logic        with_data;
   logic        hdr4;
   logic        trusted;
   modport user (output dw, input cls, ok, with_data, hdr4, trusted);
   modport dec  (input dw, output cls, ok, with_data, hdr4, trusted);
endinterface : thc_class_if

// *** design/thc_classify.sv ***
`timescale 1ns/10ps
`include "thc_defs.svh"
// Pure combinational classifier of the format and type fields.
module thc_classify
   import thc_pkg::*;
(
   thc_class_if.dec c
);
   wire [2:0] fmt       = c.dw[`THC_FMT_HI:`THC_FMT_LO];
   wire [4:0] ty        = c.dw[`THC_TYPE_HI:`THC_TYPE_LO];
   wire       f_nd3     = fmt == `THC_FMT_3DW_ND;
   wire       f_nd4     = fmt == `THC_FMT_4DW_ND;
   wire       f_d3      = fmt == `THC_FMT_3DW_D;
   wire       f_d4      = fmt == `THC_FMT_4DW_D;
   wire       f_nd      = f_nd3 | f_nd4;
   wire       f_d       = f_d3 | f_d4;
   wire       t_atomic  = ty == `THC_TY_FADD || ty == `THC_TY_SWAP || ty == `THC_TY_CAS;
   wire       t_msg     = ty[4:3] == `THC_TY_MSG_HI;
   wire       t_cfg     = ty == `THC_TY_CFG0 || ty == `THC_TY_CFG1;
   thc_class_t cls;

   // Permitted combinations; everything else is reserved and flagged.
   always_comb
   begin
      cls = THC_CLS_BAD;
      if (fmt == `THC_FMT_PREFIX)
         cls = THC_CLS_PREFIX;
      else if (ty == `THC_TY_MEM && f_nd)
         cls = THC_CLS_MEM_RD;
      else if (ty == `THC_TY_MEM_LK && f_nd)
         cls = THC_CLS_MEM_RD_LK;
      else if (ty == `THC_TY_MEM && f_d)
         cls = THC_CLS_MEM_WR;
      else if (ty == `THC_TY_IO && f_nd3)
         cls = THC_CLS_IO_RD;
      else if (ty == `THC_TY_IO && f_d3)
         cls = THC_CLS_IO_WR;
      else if (t_cfg && f_nd3)
         cls = THC_CLS_CFG_RD;
      else if (t_cfg && f_d3)
         cls = THC_CLS_CFG_WR;
      else if (t_msg && f_nd4)
         cls = THC_CLS_MSG;
      else if (t_msg && f_d4)
         cls = THC_CLS_MSG_D;
      else if (ty == `THC_TY_CPL && f_nd3)
         cls = THC_CLS_CPL;
      else if (ty == `THC_TY_CPL && f_d3)
         cls = THC_CLS_CPL_D;
      else if (ty == `THC_TY_CPL_LK && f_nd3)
         cls = THC_CLS_CPL_LK;
      else if (ty == `THC_TY_CPL_LK && f_d3)
         cls = THC_CLS_CPL_D_LK;
      else if (t_atomic && f_d)
         cls = THC_CLS_ATOMIC;
   end

   // Trusted requests are not implemented here, so they stay in the bad class.
   assign c.trusted   = ty == `THC_TY_TCFG && (f_nd3 || f_d3);
   assign c.cls       = cls;
   assign c.ok        = cls != THC_CLS_BAD;
   assign c.with_data = f_d;
   assign c.hdr4      = f_nd4 | f_d4;
endmodule : thc_classify

// *** design/thc_codec.sv ***
`timescale 1ns/10ps
`include "thc_defs.svh"
module thc_codec
   import thc_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rstn,
   // Encode side: fields from the local transaction layer.
   input  wire logic        enc_valid,
   output logic             enc_ready,
   input  wire logic [2:0]  enc_fmt,
   input  wire logic [4:0]  enc_type,
   input  wire logic [2:0]  enc_traffic_class_field,
   input  wire logic        enc_hints_present_bit,
   input  wire logic [2:0]  enc_attr,
   input  wire logic        enc_digest_present_bit,
   input  wire logic        enc_poisoned_bit,
   input  wire logic [9:0]  enc_length,
   output logic             enc_out_valid,
   input  wire logic        enc_out_ready,
   output logic [31:0]      enc_dw,
   output logic             enc_reject,
   // Decode side: first header doubleword from the link.
   input  wire logic        dec_valid,
   input  wire logic [31:0] dec_dw,
   input  wire logic [15:0] dec_txn_id,
   input  wire logic [15:0] pend_txn_id,
   input  wire logic        pend_valid,
   output logic             dec_out_valid,
   output logic [3:0]       dec_class,
   output logic [2:0]       dec_traffic_class_field,
   output logic             dec_hints_present_bit,
   output logic [2:0]       dec_attr,
   output logic             dec_digest_present_bit,
   output logic             dec_poisoned_bit,
   output logic [10:0]      dec_payload_dw,
   output logic [2:0]       dec_hdr_dw,
   output logic [11:0]      dec_total_dw,
   output logic             dec_has_payload,
   output logic [2:0]       dec_route,
   output logic             dec_unsupported,
   output logic             dec_malformed,
   output logic             dec_cpl_match
);
   // Encoder: a request is taken on an edge where enc_valid and enc_ready are
   // both high. A legal header appears one cycle later and stands until the
   // edge where enc_out_ready is high; a refused one gives a one-cycle
   // enc_reject pulse instead. Only one header is in flight, so enc_ready is
   // low while one is held.
   // Decoder: every edge with dec_valid high takes a header; the results appear
   // one cycle later and stand until the next header, while dec_out_valid
   // stands for one cycle only.
   // Two classifier copies are used so that the outgoing and incoming paths
   // never wait for each other.

   thc_class_if enc_c ();
   thc_class_if dec_c ();
   thc_classify u_enc_cls (.c(enc_c));
   thc_classify u_dec_cls (.c(dec_c));

   thc_enc_state_t st_q;
   thc_enc_state_t st_d;
   logic [31:0]    enc_dw_q;
   logic           rej_q;

   // Packing: every bit not named below is reserved and is held at zero.
   wire        enc_has_len = enc_fmt == `THC_FMT_3DW_D || enc_fmt == `THC_FMT_4DW_D
                             || enc_type == `THC_TY_MEM || enc_type == `THC_TY_MEM_LK;
   wire [9:0]  enc_len_f   = enc_has_len ? enc_length : `THC_ZERO_LEN;
   wire [31:0] enc_pack;
   // Byte 0: format and type.
   assign enc_pack[`THC_FMT_HI:`THC_FMT_LO]     = enc_fmt;
   assign enc_pack[`THC_TYPE_HI:`THC_TYPE_LO]   = enc_type;

   // Byte 1: traffic class, high attribute bit and hints flag.
   assign enc_pack[`THC_RSV_A_BIT]              = 1'b0;
   assign enc_pack[`THC_TC_HI:`THC_TC_LO]       = enc_traffic_class_field;
   assign enc_pack[`THC_RSV_B_BIT]              = 1'b0;
   assign enc_pack[`THC_ATTR2_BIT]              = enc_attr[2];
   assign enc_pack[`THC_RSV_C_BIT]              = 1'b0;
   assign enc_pack[`THC_TH_BIT]                 = enc_hints_present_bit;

   // Byte 2: digest flag, poison flag and the low attribute bits.
   assign enc_pack[`THC_TD_BIT]                 = enc_digest_present_bit;
   assign enc_pack[`THC_EP_BIT]                 = enc_poisoned_bit;
   assign enc_pack[`THC_ATTR_HI:`THC_ATTR_LO]   = enc_attr[1:0];
   assign enc_pack[`THC_RSV_D_HI:`THC_RSV_D_LO] = 2'h0;
   // Byte 3 and the two low bits of byte 2: payload length.
   assign enc_pack[`THC_LEN_HI:`THC_LEN_LO]     = enc_len_f;
   assign enc_c.dw = enc_pack;

   // Reserved and deprecated combinations are refused rather than built.
   wire enc_legal = enc_c.ok && !enc_c.trusted;
   wire enc_take  = enc_valid && enc_ready;
   wire enc_load  = enc_take && enc_legal;
   assign enc_ready     = st_q == THC_ENC_IDLE;
   assign enc_out_valid = st_q == THC_ENC_HOLD;
   assign enc_dw        = enc_dw_q;
   assign enc_reject    = rej_q;

   // Next state. One header is held until the link side accepts it, and it is
   // released only on the edge where the link is ready.
   always_comb
   begin
      st_d = st_q;
      case (st_q)
         THC_ENC_IDLE:
            if (enc_load)
               st_d = THC_ENC_HOLD;
         THC_ENC_HOLD:
            if (enc_out_ready)
               st_d = THC_ENC_IDLE;
         default:
            st_d = THC_ENC_IDLE;
      endcase
   end

   // Encoder state register.
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         st_q <= THC_ENC_IDLE;
      else
         st_q <= st_d;
   end

   // The held word changes only on acceptance, so a stalled link sees a stable
   // header; the price is one cycle of latency on every header.
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         enc_dw_q <= 32'h0;
      else if (enc_load)
         enc_dw_q <= enc_pack;
   end

   // A refused request leaves no trace but this one-cycle pulse.
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         rej_q <= 1'b0;
      else
         rej_q <= enc_take && !enc_legal;
   end

   // Field extraction; reserved positions are simply never read.
   assign dec_c.dw = dec_dw;
   wire [9:0]  d_len   = dec_dw[`THC_LEN_HI:`THC_LEN_LO];
   wire        d_td    = dec_dw[`THC_TD_BIT];
   wire [10:0] d_pay   = (d_len == `THC_ZERO_LEN) ? `THC_LEN_MAX : {1'b0, d_len};
   wire [10:0] d_pay_g = dec_c.with_data ? d_pay : 11'h000;
   wire [2:0]  d_hdr   = dec_c.hdr4 ? `THC_HDR4 : `THC_HDR3;
   wire [11:0] d_total = {1'b0, d_pay_g} + {9'h000, d_hdr} + {11'h000, d_td};
   wire        d_cpl   = dec_c.cls == THC_CLS_CPL || dec_c.cls == THC_CLS_CPL_D
                         || dec_c.cls == THC_CLS_CPL_LK || dec_c.cls == THC_CLS_CPL_D_LK;
   wire        d_match = d_cpl && pend_valid && dec_txn_id == pend_txn_id;

   // Registered copies of the decoded fields. The ports only mirror them, so
   // every decode output comes straight from a flip-flop.
   logic        out_valid_q;
   logic [3:0]  class_q;
   logic [2:0]  tclass_q;
   logic        hints_q;
   logic [2:0]  attr_q;
   logic        digest_q;
   logic        poison_q;
   logic [10:0] pay_q;
   logic [2:0]  hdr_q;
   logic [11:0] total_q;
   logic        has_pay_q;
   logic [2:0]  route_q;
   logic        unsup_q;
   logic        malf_q;
   logic        match_q;

   // The valid flag follows every beat. It stands for one cycle only, while
   // the fields below hold until the next header arrives.
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         out_valid_q <= 1'b0;
      else
         out_valid_q <= dec_valid;
   end

   // Class and error flags are taken together so they never disagree.
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         class_q <= 4'h0;
         unsup_q <= 1'b0;
         malf_q  <= 1'b0;
      end
      else if (dec_valid)
      begin
         class_q <= dec_c.cls;
         unsup_q <= !dec_c.ok;
         malf_q  <= dec_c.trusted;
      end
   end

   // Transaction fields; the reserved positions between them are never read.
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         tclass_q <= 3'h0;
         hints_q  <= 1'b0;
         attr_q   <= 3'h0;
         digest_q <= 1'b0;
         poison_q <= 1'b0;
      end
      else if (dec_valid)
      begin
         tclass_q <= dec_dw[`THC_TC_HI:`THC_TC_LO];
         hints_q  <= dec_dw[`THC_TH_BIT];
         attr_q   <= {dec_dw[`THC_ATTR2_BIT], dec_dw[`THC_ATTR_HI:`THC_ATTR_LO]};
         digest_q <= d_td;
         poison_q <= dec_dw[`THC_EP_BIT];
      end
   end

   // Size results. A length of zero stands for the largest payload, and the
   // total counts the digest word on top of header and payload.
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         pay_q     <= 11'h000;
         hdr_q     <= 3'h0;
         total_q   <= 12'h000;
         has_pay_q <= 1'b0;
      end
      else if (dec_valid)
      begin
         pay_q     <= d_pay_g;
         hdr_q     <= d_hdr;
         total_q   <= d_total;
         has_pay_q <= dec_c.with_data;
      end
   end

   // Routing and completion matching. Only one pending identifier is compared,
   // so a user with several outstanding requests must match the rest outside.
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         route_q <= 3'h0;
         match_q <= 1'b0;
      end
      else if (dec_valid)
      begin
         route_q <= dec_dw[`THC_ROUTE_HI:`THC_TYPE_LO];
         match_q <= d_match;
      end
   end

   // The output ports are plain copies of the registers above.
   assign dec_out_valid           = out_valid_q;
   assign dec_class               = class_q;
   assign dec_traffic_class_field = tclass_q;
   assign dec_hints_present_bit   = hints_q;
   assign dec_attr                = attr_q;
   assign dec_digest_present_bit  = digest_q;
   assign dec_poisoned_bit        = poison_q;
   assign dec_payload_dw          = pay_q;
   assign dec_hdr_dw              = hdr_q;
   assign dec_total_dw            = total_q;
   assign dec_has_payload         = has_pay_q;
   assign dec_route               = route_q;
   assign dec_unsupported         = unsup_q;
   assign dec_malformed           = malf_q;
   assign dec_cpl_match           = match_q;
endmodule : thc_codec

// *** design/thc_defs.svh ***
`ifndef THC_DEFS_SVH
`define THC_DEFS_SVH
// Field positions inside the first header doubleword, byte 0 in bits 31:24.
`define THC_FMT_HI     31
`define THC_FMT_LO     29
`define THC_TYPE_HI    28
`define THC_TYPE_LO    24
`define THC_TC_HI      22
`define THC_TC_LO      20
`define THC_ATTR2_BIT  18
`define THC_TH_BIT     16
`define THC_TD_BIT     15
`define THC_EP_BIT     14
`define THC_ATTR_HI    13
`define THC_ATTR_LO    12
`define THC_LEN_HI     9
`define THC_LEN_LO     0
// Reserved positions of the first doubleword; always zero when a header is built.
`define THC_RSV_A_BIT  23
`define THC_RSV_B_BIT  19
`define THC_RSV_C_BIT  17
`define THC_RSV_D_HI   11
`define THC_RSV_D_LO   10
// Top bit of the routing sub-field, the low three type bits.
`define THC_ROUTE_HI   26
// Format encodings.
`define THC_FMT_3DW_ND 3'h0
`define THC_FMT_4DW_ND 3'h1
`define THC_FMT_3DW_D  3'h2
`define THC_FMT_4DW_D  3'h3
`define THC_FMT_PREFIX 3'h4
// Type encodings.
`define THC_TY_MEM     5'h00
`define THC_TY_MEM_LK  5'h01
`define THC_TY_IO      5'h02
`define THC_TY_CFG0    5'h04
`define THC_TY_CFG1    5'h05
`define THC_TY_CPL     5'h0a
`define THC_TY_CPL_LK  5'h0b
`define THC_TY_FADD    5'h0c
`define THC_TY_SWAP    5'h0d
`define THC_TY_CAS     5'h0e
`define THC_TY_TCFG    5'h1b
`define THC_TY_MSG_HI  2'h2
// Size constants in doublewords.
`define THC_HDR3       3'h3
`define THC_HDR4       3'h4
`define THC_LEN_MAX    11'h400
`define THC_ZERO_LEN   10'h000
`define THC_TAG_W      16
`endif

// *** design/thc_pkg.sv ***
package thc_pkg;
   // Packet classes derived from format and type.
   typedef enum logic [3:0] {
      THC_CLS_MEM_RD, THC_CLS_MEM_RD_LK, THC_CLS_MEM_WR, THC_CLS_IO_RD, THC_CLS_IO_WR,
      THC_CLS_CFG_RD, THC_CLS_CFG_WR, THC_CLS_MSG, THC_CLS_MSG_D, THC_CLS_CPL,
      THC_CLS_CPL_D, THC_CLS_CPL_LK, THC_CLS_CPL_D_LK, THC_CLS_ATOMIC, THC_CLS_PREFIX,
      THC_CLS_BAD
   } thc_class_t;
   // Encoder state.
   typedef enum logic [1:0] {THC_ENC_IDLE, THC_ENC_HOLD} thc_enc_state_t;
endpackage : thc_pkg

// *** sim/tb_tlp_header_field_codec.sv ***
`timescale 1ns/10ps
module tb_tlp_header_field_codec
   import thc_pkg::*;
   ;
   logic        clk, rstn, slow, got, enc_valid, enc_ready, enc_hints_present_bit;
   logic        enc_digest_present_bit, enc_poisoned_bit, enc_out_valid, enc_out_ready;
   logic        enc_reject, dec_valid, pend_valid, dec_out_valid, dec_hints_present_bit;
   logic        dec_digest_present_bit, dec_poisoned_bit, dec_has_payload;
   logic        dec_unsupported, dec_malformed, dec_cpl_match;
   logic [2:0]  enc_fmt, enc_traffic_class_field, enc_attr, dec_traffic_class_field;
   logic [2:0]  dec_attr, dec_hdr_dw, dec_route;
   logic [3:0]  dec_class;
   logic [4:0]  enc_type;
   logic [9:0]  enc_length;
   logic [10:0] dec_payload_dw;
   logic [11:0] dec_total_dw;
   logic [15:0] dec_txn_id, pend_txn_id;
   logic [31:0] enc_dw, dec_dw, got_dw;
   int          num_errors = 0;
   int          n_checks = 0;
   int          cycles = 0;
   // Format, type and class packed 3+5+4; class 4'hf marks a code that must be refused.
   localparam logic [11:0] TBL [28] = '{12'h000, 12'h200, 12'h011, 12'h402, 12'h602,
      12'h023, 12'h424, 12'h045, 12'h446, 12'h055, 12'h456, 12'h337, 12'h748, 12'h0a9,
      12'h4aa, 12'h0bb, 12'h4bc, 12'h4cd, 12'h6dd, 12'h4ed, 12'h90e, 12'h1bf, 12'h5bf,
      12'ha0f, 12'h22f, 12'h6af, 12'h03f, 12'h10f};

   thc_codec uut (.*);
   thc_peer u_peer (.*);

   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // A hang ends the run well after the expected hundred or so cycles.
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         num_errors++;
         summarize();
      end
   end

   task automatic tick();
      @(posedge clk);
      #1;
   endtask : tick
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
      n_checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   // The line shows the inverse after the beat so stale data cannot pass.
   task automatic dec(input logic [31:0] dw);
      dec_dw = dw;
      dec_valid = 1'b1;
      tick();
      dec_valid = 1'b0;
      dec_dw = ~dw;
      chk("dec_out_valid", 1'b1, dec_out_valid);
   endtask : dec
   task automatic summarize();
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : summarize

   initial
   begin : main
      logic [2:0]  f;
      logic [4:0]  t;
      logic [3:0]  c;
      logic [9:0]  n;
      logic [31:0] e;
      int          k;
      {rstn, slow, enc_valid, dec_valid, pend_valid} = 5'h0;
      {enc_fmt, enc_type, enc_traffic_class_field, enc_attr, enc_length} = 24'h0;
      {enc_hints_present_bit, enc_digest_present_bit, enc_poisoned_bit} = 3'h0;
      {dec_dw, dec_txn_id, pend_txn_id} = 64'h0;
      repeat (16) @(posedge clk);
      #1 rstn = 1'b1;
      for (int i = 0; i < 28; i++)
      begin
         {f, t, c} = TBL[i];
         n = 10'(i * 256);
         e = {f, t, 1'b0, 3'(i), 1'b0, i[4], 1'b0, i[3], i[0], i[1], i[3:2], 2'h0,
              (f[1] || (!f[2] && t[4:1] == 4'h0)) ? n : 10'h0};
         slow = i[2];
         {enc_fmt, enc_type, enc_traffic_class_field, enc_attr, enc_length} =
            {f, t, 3'(i), 3'(i >> 2), n};
         {enc_hints_present_bit, enc_digest_present_bit, enc_poisoned_bit} = {i[3], i[0], i[1]};
         enc_valid = 1'b1;
         tick();
         enc_valid = 1'b0;
         chk("enc_reject", c == 4'hf, enc_reject);
         for (k = 0; k < 8 && c != 4'hf && !got; k++)
            tick();
         if (c < 4'he)
            chk("enc_dw", e, got_dw);
         pend_valid = 1'b1;
         dec_txn_id = 16'h1235;
         pend_txn_id = 16'h1234 | 16'(i & 1);
         // Reserved positions are set on the way in; the decoder must ignore them.
         dec((c == 4'hf ? e : got_dw) | 32'h008a0c00);
         chk("dec_route", t[2:0], dec_route);
         chk("dec_class", c, dec_class);
         chk("dec_unsupported", c == 4'hf, dec_unsupported);
         chk("dec_malformed", t == 5'h1b && !f[2] && !f[0], dec_malformed);
         chk("dec_cpl_match", c inside {[4'h9:4'hc]} && i[0], dec_cpl_match);
         if (c < 4'he)
         begin
            chk("dec_payload_dw", f[1] ? (n == 0 ? 11'h400 : 11'(n)) : 11'h0,
                dec_payload_dw);
            chk("dec_hdr_dw", f[0] ? 3'h4 : 3'h3, dec_hdr_dw);
            chk("dec_total_dw", 12'(f[1] ? (n == 0 ? 11'h400 : 11'(n)) : 11'h0)
                + (f[0] ? 12'h4 : 12'h3) + 12'(i[0]), dec_total_dw);
            chk("dec_fields", {i[3], i[0], i[1], i[4:2], 3'(i), f[1]}, {dec_hints_present_bit,
                dec_digest_present_bit, dec_poisoned_bit, dec_attr,
                dec_traffic_class_field, dec_has_payload});
         end
         $display("test %0d done", i);
      end
      summarize();
   end
endmodule : tb_tlp_header_field_codec

// *** sim/thc_codec_asserts.sv ***
`timescale 1ns/10ps
// Watches the codec's ports; every bound relation holds in the same cycle or in the next one.
module thc_codec_asserts (
   input wire logic        clk,
   input wire logic        rstn,
   input wire logic        enc_valid,
   input wire logic        enc_ready,
   input wire logic [2:0]  enc_fmt,
   input wire logic [4:0]  enc_type,
   input wire logic        enc_poisoned_bit,
   input wire logic        enc_out_valid,
   input wire logic        enc_out_ready,
   input wire logic [31:0] enc_dw,
   input wire logic        enc_reject,
   input wire logic        dec_valid,
   input wire logic [31:0] dec_dw,
   input wire logic        dec_out_valid,
   input wire logic [2:0]  dec_traffic_class_field,
   input wire logic [10:0] dec_payload_dw,
   input wire logic [2:0]  dec_hdr_dw,
   input wire logic [11:0] dec_total_dw,
   input wire logic        dec_digest_present_bit,
   input wire logic [2:0]  dec_route,
   input wire logic        dec_cpl_match,
   input wire logic        dec_malformed
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);

   // A stalled link must see the same header until it takes it.
   property p_hold;
      enc_out_valid && !enc_out_ready |=> enc_out_valid && $stable(enc_dw);
   endproperty
   a_hold: assert property (p_hold) else $error("held header changed");
   property p_rsvd;
      enc_out_valid |-> !enc_dw[23] && !enc_dw[19] && !enc_dw[17] && enc_dw[11:10] == 2'h0;
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved header bit set");
   property p_poison;
      enc_valid && enc_ready |=> enc_reject || enc_dw[14] == $past(enc_poisoned_bit);
   endproperty
   a_poison: assert property (p_poison) else $error("poison bit misplaced");
   property p_trusted;
      enc_valid && enc_ready && enc_type == 5'h1b && (enc_fmt == 3'h0 || enc_fmt == 3'h2)
         |=> enc_reject && !enc_out_valid;
   endproperty
   a_trusted: assert property (p_trusted) else $error("deprecated type sent");
   property p_lat;
      dec_valid |=> dec_out_valid;
   endproperty
   a_lat: assert property (p_lat) else $error("decode result late");
   property p_tc;
      dec_valid |=> dec_traffic_class_field == $past(dec_dw[22:20]);
   endproperty
   a_tc: assert property (p_tc) else $error("traffic class wrong");
   property p_route;
      dec_valid |=> dec_route == $past(dec_dw[26:24]);
   endproperty
   a_route: assert property (p_route) else $error("route field wrong");
   property p_len;
      dec_valid && dec_dw[31:30] == 2'h1 && dec_dw[28:24] == 5'h00
         |=> dec_payload_dw == {~|$past(dec_dw[9:0]), $past(dec_dw[9:0])};
   endproperty
   a_len: assert property (p_len) else $error("payload size wrong");
   property p_total;
      dec_out_valid |-> dec_total_dw == 12'(dec_payload_dw) + 12'(dec_hdr_dw)
         + 12'(dec_digest_present_bit);
   endproperty
   a_total: assert property (p_total) else $error("total size wrong");
   c_reject: cover property (enc_reject);
   c_stall: cover property (enc_out_valid && !enc_out_ready);
   c_match: cover property (dec_cpl_match);
   c_bad: cover property (dec_malformed);
endmodule : thc_codec_asserts

bind thc_codec thc_codec_asserts u_asserts (.*);

// *** sim/thc_peer.sv ***
`timescale 1ns/10ps
// Far transaction layer; when slow it holds ready low two cycles per header.
module thc_peer (
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic        slow,
   input  wire logic        enc_out_valid,
   input  wire logic [31:0] enc_dw,
   output logic             enc_out_ready,
   output logic             got,
   output logic [31:0]      got_dw
);
   logic [1:0] wait_q;
   logic       take;
   // Stalling forces the codec to hold its header across several edges.
   assign enc_out_ready = !slow || (wait_q == 2'h2);
   assign take          = enc_out_valid && enc_out_ready;
   // The whole word is kept so the bench can check every bit of it.
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         wait_q <= 2'h0;
         got    <= 1'b0;
         got_dw <= 32'h0;
      end
      else
      begin
         got <= take;
         if (take)
         begin
            got_dw <= enc_dw;
            wait_q <= 2'h0;
         end
         else if (enc_out_valid)
            wait_q <= wait_q + 2'h1;
      end
   end
endmodule : thc_peer
